/* File: rtl/psv_defs.svh */
// Command codes, bit positions, reset values and timing figures of the
// status and input-voltage telemetry bank.
// Assumes it is included by bare name from the design and bench files.
`ifndef PSV_DEFS_SVH
`define PSV_DEFS_SVH

// Command codes answered by this bank.
`define PSV_CMD_MISC 8'h7F
`define PSV_CMD_VENDOR 8'h80
`define PSV_CMD_VIN 8'h88

// Field positions inside the misc and vendor status bytes.
`define PSV_MISC_EARLY 0
`define PSV_VND_POR 7
`define PSV_VND_SELF 6
`define PSV_VND_ORST 3
`define PSV_VND_BACKCH 2
`define PSV_VND_SYNC 1

// Reset value of every latched status byte.
`define PSV_STAT_RST 8'h00
// Reset value of the reading register and of the read data.
`define PSV_WORD_RST 16'h0000

// Phase value that selects the loop controller's own rail reading.
`define PSV_PHASE_ALL 8'hFF

// Reading format: fixed exponent of -5 gives 1/32 V per mantissa step.
`define PSV_VIN_EXP 5'h1B
// Top of the reporting range, 24 V at 1/32 V per step.
`define PSV_VIN_MAN_MAX 11'h300
`define PSV_VIN_MAN_ZERO 11'h000

// Timing figures in their own units, and the core clock rate.
`define PSV_CLK_MHZ 25
`define PSV_VIN_REFRESH_US 1000
`define PSV_SYNC_LOSS_NS 2000

`endif

/* File: rtl/psv_pkg.sv */
// Types shared by the status and telemetry bank and its neighbours.
// Assumes psv_defs.svh is on the include path.
package psv_pkg;

    // One command from the bus protocol engine: code plus write byte.
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] wdata;
    } psv_cmd_t;

    // Results of the power-on checks, each high while invalid.
    typedef struct packed {
        logic trim_bad;
        logic nvm_bad;
        logic pin_bad;
    } psv_por_chk_t;

    // Linear word: two's-complement exponent over two's-complement mantissa.
    typedef struct packed {
        logic [4:0] exp;
        logic [10:0] man;
    } psv_slin11_t;

endpackage : psv_pkg

/* File: rtl/psv_sync_monitor.sv */
// Watches the frequency-synchronisation input and flags its loss.
// Assumes the input is asynchronous to the core clock and slow enough
// to be sampled by it.
`timescale 1ns/100ps
`include "psv_defs.svh"

module psv_sync_monitor #(
    parameter int LOSS_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sync_en_i,
    input wire logic sync_pin_i,
    output logic fault_o
);
    import psv_pkg::*;

    localparam int CW = $clog2(LOSS_CYCLES + 1);
    localparam logic [CW-1:0] LOSS_LAST = CW'(LOSS_CYCLES - 1);

    logic meta; // First synchroniser stage, read only by the second.
    logic sync_s; // Second synchroniser stage.
    logic sync_d; // Delayed copy for edge finding.
    logic [CW-1:0] gap; // Cycles since the last rising edge.
    logic lost; // Holds off repeat reports until an edge returns.

    // Two-flop synchroniser plus one stage for the edge detector.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta <= sync_pin_i;
            sync_s <= meta;
            sync_d <= sync_s;
        end
    end

    // Count the gap between rising edges; report once per loss.
    always_ff @(posedge clk_i) begin
        if (rst_i || !sync_en_i) begin
            gap <= '0;
            lost <= 1'b0;
            fault_o <= 1'b0;
        end else if (sync_s && !sync_d) begin
            gap <= '0;
            lost <= 1'b0;
            fault_o <= 1'b0;
        end else if (gap == LOSS_LAST && !lost) begin
            // A missing edge is a fault; a single pulse is enough to latch.
            lost <= 1'b1;
            fault_o <= 1'b1;
        end else begin
            if (!lost) begin
                gap <= gap + 1'b1;
            end
            fault_o <= 1'b0;
        end
    end

endmodule : psv_sync_monitor

/* File: rtl/psv_status_vin.sv */
// Status and input-voltage telemetry bank: the misc status byte, the
// vendor fault status byte and the input-voltage reading word.
// Assumes a bus protocol engine on the same clock that hands over one
// command per pulse, and an analogue front end delivering raw mantissas.
//
// Overview of operation
// - Misc byte at 7Fh, upper seven bits zero.
// - Earliest-alert flag set when we alerted first.
// - Earliest-alert flag zero if alert cleared or late.
// - Misc summary bit is OR of misc bits.
// - Clearing misc bit clears its summary bit.
// - Vendor byte at 80h, cleared per bit or globally.
// - Bit 7 latches on any invalid power-on check.
// - Bit 6 live while self-check or followers pending.
// - Bit 3 latches on output reset event.
// - Bit 2 latches on back-channel fault.
// - Bit 1 latches on synchronisation input fault.
// - Vendor bits 5, 4 and 0 read zero.
// - Writing one clears a set bit; zero keeps.
// - Each alerting bit has a mask bit gating it.
// - Reading at 88h is exponent and mantissa word.
// - Reading refreshed each millisecond, range 0 to 24 V.
// - Write to reading flags an invalid command.
// - Phase FFh reports the loop controller's rail.
// - Phases 0 to NPH-1 report the selected device's rail; other phases read zero.
// - Followers report back-channel faults as communication faults.
`timescale 1ns/100ps
`include "psv_defs.svh"

module psv_status_vin #(
    parameter int NPH = 4,
    parameter int REFRESH_CYCLES = `PSV_VIN_REFRESH_US * `PSV_CLK_MHZ,
    parameter int SYNC_LOSS_CYCLES = `PSV_SYNC_LOSS_NS * `PSV_CLK_MHZ / 1000
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CMD_WR_I,
    input wire logic CMD_RD_I,
    input wire psv_pkg::psv_cmd_t CMD_I,
    output logic [15:0] RD_DATA_O,
    output logic RD_VALID_O,
    input wire logic CLEAR_FAULTS_I,
    input wire logic ALERT_N_I,
    output logic ALERT_N_O,
    output logic ALERT_N_OE_O,
    input wire logic [7:0] MASK_VENDOR_I,
    input wire logic MASK_INV_CMD_I,
    input wire logic INV_CMD_CLR_I,
    input wire psv_pkg::psv_por_chk_t POR_CHK_I,
    input wire logic SELF_CHECK_BUSY_I,
    input wire logic [NPH-1:0] FOLLOWER_EXPECT_I,
    input wire logic [NPH-1:0] FOLLOWER_RESP_I,
    input wire logic OUT_RESET_EVT_I,
    input wire logic BACK_CHAN_FAULT_I,
    input wire logic IS_FOLLOWER_I,
    input wire logic SYNC_EN_I,
    input wire logic SYNC_PIN_I,
    input wire logic [7:0] PHASE_SEL_I,
    input wire logic [10:0] CTRL_VIN_MAN_I,
    input wire logic [NPH*11-1:0] PHASE_VIN_MAN_I,
    output logic MISC_SUM_O,
    output logic CML_SUM_O,
    output logic INV_CMD_FLAG_O,
    output logic COMM_FAULT_O
);
    import psv_pkg::*;

    localparam int RW = $clog2(REFRESH_CYCLES + 1);
    localparam logic [RW-1:0] REFRESH_LAST = RW'(REFRESH_CYCLES - 1);
    // Only the vendor bits that are latched take part in clearing.
    localparam logic [7:0] VND_LATCHED = (8'h01 << `PSV_VND_POR)
        | (8'h01 << `PSV_VND_ORST) | (8'h01 << `PSV_VND_BACKCH)
        | (8'h01 << `PSV_VND_SYNC);

    logic [7:0] vendor; // Latched vendor fault bits.
    logic [7:0] vendor_view; // Latched bits plus the live bit.
    logic early_flag; // We were the first on the bus to alert.
    logic inv_cmd; // Invalid command latch toward the CML byte.
    logic alert_req; // Unmasked fault present, pull the line low.
    logic alert_req_q; // Previous alert request for edge finding.
    logic alert_meta; // First stage of the alert line synchroniser.
    logic alert_low_s; // Synchronised: someone holds the line low.
    logic sync_fault; // Loss pulse from the synchronisation monitor.
    logic self_pending; // Live self-check state.
    logic [RW-1:0] tick_cnt; // Counts toward the next refresh.
    logic tick; // One-cycle refresh strobe.
    psv_slin11_t reading; // Held reading returned at 88h.
    logic [10:0] next_man; // Raw mantissa of the selected phase.
    logic [10:0] next_clamped; // Mantissa forced into the range.
    logic wr_misc; // Write to the misc byte this cycle.
    logic wr_vendor; // Write to the vendor byte this cycle.
    logic wr_vin; // Write to the read-only reading this cycle.
    logic [7:0] vendor_set; // Fault events arriving this cycle.
    logic [7:0] vendor_clr; // Bits that software clears this cycle.
    logic [7:0] rd_code; // Code of the read being answered.

    // Loss of the synchronisation input is watched in its own module.
    psv_sync_monitor #(
        .LOSS_CYCLES(SYNC_LOSS_CYCLES)
    ) u_sync_mon (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .sync_en_i(SYNC_EN_I),
        .sync_pin_i(SYNC_PIN_I),
        .fault_o(sync_fault)
    );

    // Decode of the write commands that belong to this bank.
    assign wr_misc = CMD_WR_I && (CMD_I.code == `PSV_CMD_MISC);
    assign wr_vendor = CMD_WR_I && (CMD_I.code == `PSV_CMD_VENDOR);
    assign wr_vin = CMD_WR_I && (CMD_I.code == `PSV_CMD_VIN);

    // Fault events feeding the vendor byte.
    always_comb begin
        vendor_set = `PSV_STAT_RST;
        vendor_set[`PSV_VND_POR] = |POR_CHK_I;
        vendor_set[`PSV_VND_ORST] = OUT_RESET_EVT_I;
        vendor_set[`PSV_VND_BACKCH] = BACK_CHAN_FAULT_I;
        vendor_set[`PSV_VND_SYNC] = sync_fault;
    end

    // Clear sources: global clear, or a one in the written byte.
    always_comb begin
        vendor_clr = `PSV_STAT_RST;
        if (CLEAR_FAULTS_I) begin
            vendor_clr = VND_LATCHED;
        end else if (wr_vendor) begin
            vendor_clr = CMD_I.wdata & VND_LATCHED;
        end
    end

    // Vendor latches: an event in the clearing cycle still sets the bit.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            vendor <= `PSV_STAT_RST;
        end else begin
            vendor <= (vendor & ~vendor_clr) | vendor_set;
        end
    end

    // The live bit is never latched; unsupported bits stay zero.
    assign self_pending = SELF_CHECK_BUSY_I
        || |(FOLLOWER_EXPECT_I & ~FOLLOWER_RESP_I);
    always_comb begin
        vendor_view = vendor & VND_LATCHED;
        vendor_view[`PSV_VND_SELF] = self_pending;
    end

    // Invalid command latch: writing a read-only word is refused.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            inv_cmd <= 1'b0;
        end else if (wr_vin) begin
            inv_cmd <= 1'b1;
        end else if (CLEAR_FAULTS_I || INV_CMD_CLR_I) begin
            inv_cmd <= 1'b0;
        end
    end
    assign INV_CMD_FLAG_O = inv_cmd;
    assign CML_SUM_O = inv_cmd;

    // A follower also raises a communication fault toward its CML byte.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            COMM_FAULT_O <= 1'b0;
        end else begin
            COMM_FAULT_O <= BACK_CHAN_FAULT_I && IS_FOLLOWER_I;
        end
    end

    // Alert request: each alerting bit is gated by its own mask bit.
    // The live bit and the earliest-alert flag never alert by themselves.
    assign alert_req = |(vendor & VND_LATCHED & ~MASK_VENDOR_I)
        || (inv_cmd && !MASK_INV_CMD_I);
    assign ALERT_N_O = 1'b0;
    assign ALERT_N_OE_O = alert_req;

    // Shared open-drain alert line, synchronised before use.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            alert_meta <= 1'b0;
            alert_low_s <= 1'b0;
            alert_req_q <= 1'b0;
        end else begin
            alert_meta <= !ALERT_N_I;
            alert_low_s <= alert_meta;
            alert_req_q <= alert_req;
        end
    end

    // Earliest-alert flag. Our own pull needs two cycles to show in the
    // synchronised line, so at our rising request a low line means that
    // another device pulled it first.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            early_flag <= 1'b0;
        end else if (alert_req && !alert_req_q) begin
            early_flag <= !alert_low_s;
        end else if (!alert_req) begin
            early_flag <= 1'b0;
        end else if (CLEAR_FAULTS_I) begin
            early_flag <= 1'b0;
        end else if (wr_misc && CMD_I.wdata[`PSV_MISC_EARLY]) begin
            early_flag <= 1'b0;
        end
    end
    // Summary follows the flag, so a clear of the flag clears it too.
    assign MISC_SUM_O = early_flag;

    // Millisecond refresh strobe.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == REFRESH_LAST) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // Phase select: FFh picks the controller, else the selected device.
    // A phase number beyond the stack reads as zero volts.
    always_comb begin
        next_man = `PSV_VIN_MAN_ZERO;
        if (PHASE_SEL_I == `PSV_PHASE_ALL) begin
            next_man = CTRL_VIN_MAN_I;
        end else begin
            for (int p = 0; p < NPH; p++) begin
                if (PHASE_SEL_I == 8'(p)) begin
                    next_man = PHASE_VIN_MAN_I[p*11 +: 11];
                end
            end
        end
    end

    // Clamp to the reporting range; a negative reading shows as zero.
    always_comb begin
        if (next_man[10]) begin
            next_clamped = `PSV_VIN_MAN_ZERO;
        end else if (next_man > `PSV_VIN_MAN_MAX) begin
            next_clamped = `PSV_VIN_MAN_MAX;
        end else begin
            next_clamped = next_man;
        end
    end

    // The reading is held between strobes so a read never tears.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            reading <= `PSV_WORD_RST;
        end else if (tick) begin
            reading.exp <= `PSV_VIN_EXP;
            reading.man <= next_clamped;
        end
    end

    // Read answer one cycle after the request; other codes stay silent
    // because the neighbouring banks answer them.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            RD_DATA_O <= `PSV_WORD_RST;
            RD_VALID_O <= 1'b0;
            rd_code <= `PSV_STAT_RST;
        end else begin
            RD_VALID_O <= 1'b0;
            rd_code <= CMD_I.code;
            if (CMD_RD_I) begin
                unique case (CMD_I.code)
                    `PSV_CMD_MISC: begin
                        RD_DATA_O <= {15'h0000, early_flag};
                        RD_VALID_O <= 1'b1;
                    end
                    `PSV_CMD_VENDOR: begin
                        RD_DATA_O <= {8'h00, vendor_view};
                        RD_VALID_O <= 1'b1;
                    end
                    `PSV_CMD_VIN: begin
                        RD_DATA_O <= reading;
                        RD_VALID_O <= 1'b1;
                    end
                    default: begin
                        RD_DATA_O <= `PSV_WORD_RST;
                    end
                endcase
            end
        end
    end

    // Checks on the bank's own behaviour.
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence alert_first_s;
        alert_req && !alert_req_q && !alert_low_s;
    endsequence
    sequence vnd_clear_s;
        wr_vendor && CMD_I.wdata[`PSV_VND_ORST] && !OUT_RESET_EVT_I;
    endsequence

    misc_upper_zero_a: assert property (
        RD_VALID_O && rd_code == `PSV_CMD_MISC |-> RD_DATA_O[15:1] == '0)
        else $error("misc byte upper bits not zero");
    first_alert_a: assert property (
        alert_first_s |=> early_flag [*1] ##1 (early_flag || !alert_req_q
        || $past(CLEAR_FAULTS_I) || $past(wr_misc)))
        else $error("earliest alert flag not set");
    late_alert_a: assert property (
        (alert_req && !alert_req_q && alert_low_s) or !alert_req
        |=> !early_flag)
        else $error("earliest alert flag set while late or cleared");
    misc_sum_a: assert property (
        wr_misc && CMD_I.wdata[`PSV_MISC_EARLY]
        && !(alert_req && !alert_req_q) |=> !MISC_SUM_O)
        else $error("misc summary outlived its flag");
    por_latch_a: assert property (
        |POR_CHK_I |=> vendor_view[`PSV_VND_POR] ##1
        (vendor_view[`PSV_VND_POR] || $past(CLEAR_FAULTS_I)
        || $past(wr_vendor)))
        else $error("power-on check fault not latched");
    self_live_a: assert property (
        RD_VALID_O && rd_code == `PSV_CMD_VENDOR
        |-> RD_DATA_O[`PSV_VND_SELF] == $past(self_pending))
        else $error("self-check bit not live");
    vnd_w1c_a: assert property (
        vnd_clear_s |=> !vendor[`PSV_VND_ORST])
        else $error("write of one did not clear bit");
    vnd_zero_a: assert property (
        RD_VALID_O && rd_code == `PSV_CMD_VENDOR
        |-> RD_DATA_O[15:8] == '0 && RD_DATA_O[5:4] == '0
        && RD_DATA_O[0] == 1'b0)
        else $error("unsupported vendor bits not zero");
    alert_gate_a: assert property (
        vendor[`PSV_VND_SYNC] && !MASK_VENDOR_I[`PSV_VND_SYNC]
        |-> ALERT_N_OE_O)
        else $error("unmasked fault did not alert");
    inv_cmd_a: assert property (
        wr_vin |=> INV_CMD_FLAG_O && CML_SUM_O)
        else $error("write to reading not flagged");
    refresh_a: assert property (
        tick |=> reading.exp == `PSV_VIN_EXP && !reading.man[10]
        && reading.man <= `PSV_VIN_MAN_MAX)
        else $error("reading out of range after refresh");
    phase_all_a: assert property (
        tick && PHASE_SEL_I == `PSV_PHASE_ALL && !CTRL_VIN_MAN_I[10]
        && CTRL_VIN_MAN_I <= `PSV_VIN_MAN_MAX
        |=> reading.man == $past(CTRL_VIN_MAN_I))
        else $error("controller reading not reported");
    follower_comm_a: assert property (
        BACK_CHAN_FAULT_I && IS_FOLLOWER_I |=> COMM_FAULT_O)
        else $error("follower back-channel fault not reported");

endmodule : psv_status_vin

/* File: verification/psv_host_model.sv */
// Host controller model for the status and telemetry bank.
// Assumes one clock shared with the bank; it drives at falling edges.
`timescale 1ns/100ps

module psv_host_model (
    input wire logic clk_i,
    input wire logic [15:0] rd_data_i,
    input wire logic rd_valid_i,
    output logic cmd_wr_o,
    output logic cmd_rd_o,
    output psv_pkg::psv_cmd_t cmd_o
);
    import psv_pkg::*;

    // Idle bus: no strobe, and junk on the code so stale values never help.
    initial begin
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_o = 16'hA5C3;
    end

    // Read: one strobe cycle, the answer is taken one cycle later.
    task automatic rd(input logic [7:0] code, output logic [15:0] data,
                      output logic vld);
        @(negedge clk_i);
        cmd_o = {code, 8'h00};
        cmd_rd_o = 1'b1;
        @(negedge clk_i);
        cmd_rd_o = 1'b0;
        cmd_o = ~cmd_o;
        data = rd_data_i;
        vld = rd_valid_i;
    endtask : rd

    // Write: ones in the data byte ask the bank to clear set bits.
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        @(negedge clk_i);
        cmd_o = {code, data};
        cmd_wr_o = 1'b1;
        @(negedge clk_i);
        cmd_wr_o = 1'b0;
        cmd_o = ~cmd_o;
    endtask : wr
endmodule : psv_host_model

/* File: verification/tb.sv */
// Self-checking bench for the status and input-voltage telemetry bank.
// Assumes psv_defs.svh on the include path and the host model compiled.
`timescale 1ns/100ps
`include "psv_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("Error %s expected %h seen %h", nm, e, g); end end

module tb;
    import psv_pkg::*;
    localparam int NPH = 4;
    logic clk, rst, other, sync_run, sync_pin, selfb, isf, sync_en;
    logic mask_inv, cmd_wr, cmd_rd, rd_valid, alert_oe, misc_sum;
    logic cml_sum, inv_flag, comm, alert_drv;
    logic [3:0] evt, fexp, fresp;
    logic [2:0] por;
    logic [7:0] mask_v, phase;
    logic [10:0] ctrl_man;
    logic [NPH*11-1:0] ph_man;
    logic [15:0] rd_data;
    psv_cmd_t cmd;
    int err_total = 0;
    int comparisons = 0;
    // Open-drain alert line with pull-up: low while anyone pulls it.
    // Our pin drives the level it is given only while enabled.
    wire alert_line = (alert_oe ? alert_drv : 1'b1) & ~other;

    psv_host_model u_host (.clk_i(clk), .rd_data_i(rd_data),
        .rd_valid_i(rd_valid), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd),
        .cmd_o(cmd));

    // Short refresh and loss counts keep the run brief.
    psv_status_vin #(.NPH(NPH), .REFRESH_CYCLES(64), .SYNC_LOSS_CYCLES(20))
    i_psv_status_vin (.CORE_CLK_I(clk), .SYS_RST_I(rst),
        .CMD_WR_I(cmd_wr), .CMD_RD_I(cmd_rd), .CMD_I(cmd),
        .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
        .CLEAR_FAULTS_I(evt[2]), .ALERT_N_I(alert_line),
        .ALERT_N_O(alert_drv),
        .ALERT_N_OE_O(alert_oe), .MASK_VENDOR_I(mask_v),
        .MASK_INV_CMD_I(mask_inv), .INV_CMD_CLR_I(evt[3]),
        .POR_CHK_I(psv_por_chk_t'(por)), .SELF_CHECK_BUSY_I(selfb),
        .FOLLOWER_EXPECT_I(fexp), .FOLLOWER_RESP_I(fresp),
        .OUT_RESET_EVT_I(evt[0]), .BACK_CHAN_FAULT_I(evt[1]),
        .IS_FOLLOWER_I(isf), .SYNC_EN_I(sync_en), .SYNC_PIN_I(sync_pin),
        .PHASE_SEL_I(phase), .CTRL_VIN_MAN_I(ctrl_man),
        .PHASE_VIN_MAN_I(ph_man), .MISC_SUM_O(misc_sum),
        .CML_SUM_O(cml_sum), .INV_CMD_FLAG_O(inv_flag),
        .COMM_FAULT_O(comm));

    // Core clock, 40 ns period.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Sync input, 320 ns period, off phase; it stands still when stopped.
    initial begin
        sync_pin = 1'b0;
        #7;
        forever begin
            #160;
            if (sync_run) sync_pin = ~sync_pin;
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // One-cycle event pulse on the chosen event input.
    task automatic pulse(input int b);
        @(negedge clk);
        evt[b] = 1'b1;
        @(negedge clk);
        evt[b] = 1'b0;
    endtask : pulse

    // Reads a command and compares the answer.
    task automatic chk_rd(input logic [7:0] code, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        u_host.rd(code, d, v);
        `CHK("read valid", 1'b1, v)
        `CHK("read data", e, d)
    endtask : chk_rd

    // Sets a reading on the selected source, waits two refreshes, reads.
    task automatic vin(input logic [7:0] p, input logic [10:0] m,
                       input logic [10:0] e);
        phase = p;
        ctrl_man = 11'h055;
        ph_man = {NPH{11'h055}};
        if (p == `PSV_PHASE_ALL) ctrl_man = m;
        else ph_man[p*11+:11] = m;
        repeat (140) @(negedge clk);
        chk_rd(`PSV_CMD_VIN, {`PSV_VIN_EXP, e});
    endtask : vin

    // A hang counts as a mismatch; the run takes some 750 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    // Main sequence.
    initial begin
        int i;
        logic seen;
        rst = 1'b1;
        {other, sync_run, selfb, isf, sync_en, mask_inv} = '0;
        {evt, fexp, fresp, por, mask_v} = '0;
        phase = 8'hFF;
        ctrl_man = 11'h055;
        ph_man = {NPH{11'h055}};
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        `CHK("alert enable", 1'b0, alert_oe)
        chk_rd(`PSV_CMD_MISC, 16'h0000);
        chk_rd(`PSV_CMD_VENDOR, 16'h0000);
        // We alert first on an output reset event.
        pulse(0);
        chk_rd(`PSV_CMD_VENDOR, 16'h0008);
        chk_rd(`PSV_CMD_MISC, 16'h0001);
        `CHK("misc summary", 1'b1, misc_sum)
        u_host.wr(`PSV_CMD_MISC, 8'hFF);
        chk_rd(`PSV_CMD_MISC, 16'h0000);
        `CHK("misc summary", 1'b0, misc_sum)
        u_host.wr(`PSV_CMD_VENDOR, 8'h08);
        chk_rd(`PSV_CMD_VENDOR, 16'h0000);
        // Another device alerts first; we are a follower.
        other = 1'b1;
        isf = 1'b1;
        repeat (3) @(negedge clk);
        pulse(1);
        seen = 1'b0;
        repeat (3) begin
            seen = seen | comm;
            @(negedge clk);
        end
        `CHK("comm fault", 1'b1, seen)
        chk_rd(`PSV_CMD_VENDOR, 16'h0004);
        chk_rd(`PSV_CMD_MISC, 16'h0000);
        other = 1'b0;
        isf = 1'b0;
        pulse(2);
        chk_rd(`PSV_CMD_VENDOR, 16'h0000);
        // A masked bit latches but leaves the line alone.
        mask_v = 8'h08;
        pulse(0);
        @(negedge clk);
        `CHK("alert enable", 1'b0, alert_oe)
        chk_rd(`PSV_CMD_VENDOR, 16'h0008);
        u_host.wr(`PSV_CMD_VENDOR, 8'h08);
        mask_v = 8'h00;
        // Each power-on check result alone sets the top bit.
        for (i = 0; i < 3; i++) begin
            por = 3'b001 << i;
            @(negedge clk);
            por = 3'b000;
            chk_rd(`PSV_CMD_VENDOR, 16'h0080);
            u_host.wr(`PSV_CMD_VENDOR, 8'hFF);
            chk_rd(`PSV_CMD_VENDOR, 16'h0000);
        end
        // Live self-check bit ignores writes.
        selfb = 1'b1;
        chk_rd(`PSV_CMD_VENDOR, 16'h0040);
        u_host.wr(`PSV_CMD_VENDOR, 8'h40);
        chk_rd(`PSV_CMD_VENDOR, 16'h0040);
        selfb = 1'b0;
        fexp = 4'b0010;
        chk_rd(`PSV_CMD_VENDOR, 16'h0040);
        fresp = 4'b0010;
        chk_rd(`PSV_CMD_VENDOR, 16'h0000);
        // Sync input running, then lost.
        sync_en = 1'b1;
        sync_run = 1'b1;
        repeat (60) @(negedge clk);
        chk_rd(`PSV_CMD_VENDOR, 16'h0000);
        sync_run = 1'b0;
        repeat (40) @(negedge clk);
        chk_rd(`PSV_CMD_VENDOR, 16'h0002);
        sync_en = 1'b0;
        u_host.wr(`PSV_CMD_VENDOR, 8'h02);
        // Readings by phase, with both ends of the range.
        vin(8'hFF, 11'h180, 11'h180);
        vin(8'h02, 11'h2A0, 11'h2A0);
        vin(8'h02, 11'h7F0, 11'h000);
        vin(8'hFF, 11'h3FF, 11'h300);
        // Writing the read-only reading is an invalid command.
        u_host.wr(`PSV_CMD_VIN, 8'h12);
        `CHK("invalid flag", 1'b1, inv_flag)
        `CHK("cml summary", 1'b1, cml_sum)
        `CHK("alert enable", 1'b1, alert_oe)
        `CHK("alert line", 1'b0, alert_line)
        pulse(3);
        `CHK("invalid flag", 1'b0, inv_flag)
        // A masked invalid command still latches but does not alert.
        mask_inv = 1'b1;
        u_host.wr(`PSV_CMD_VIN, 8'h34);
        `CHK("invalid flag", 1'b1, inv_flag)
        `CHK("alert enable", 1'b0, alert_oe)
        complete_run();
    end
endmodule : tb
